// ==== shared/rspl_map.svh ====
`ifndef RSPL_MAP_SVH
`define RSPL_MAP_SVH
// ***************************************************************
// Register map and reset values
// ***************************************************************
`define RSPL_SUPPLY_CFG_ADDR    16'h4134
`define RSPL_SUPPLY_CFG_RESET   8'hc1
`define RSPL_SUPPLY_CFG_DYNAMIC 8'h41
`define RSPL_FIXED_ADDR         16'h4135
`define RSPL_STATUS_ADDR        16'h4136
`define RSPL_FIXED_RESET        4'h0
`define RSPL_STAT_SELF_BIT      0
`define RSPL_STAT_DYN_BIT       1
`define RSPL_STAT_READY_BIT     2
`define RSPL_CFG_CYCLES         4'h4
`endif

// ==== shared/rspl_pkg.sv ====
package rspl_pkg;
   typedef enum logic [3:0]
   {
      RSPL_STANDBY = 4'h1,
      RSPL_LATCH   = 4'h2,
      RSPL_CONFIG  = 4'h4,
      RSPL_RUN     = 4'h8
   } rspl_state_t;
   typedef logic [7:0] rspl_byte_t;
endpackage

// ==== src/rspl_strap_hold.sv ====
`timescale 1ns/1ps
`include "rspl_map.svh"
// Strap holding register: loads all straps together in one cycle.
module rspl_strap_hold #(
   parameter int W = 8
)(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         clear,
   input  wire logic         load,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         dout <= '0;
      else if (ce)
      begin
         if (clear)
            dout <= '0;
         else if (load)
            dout <= din;
      end
   end
endmodule

// ==== src/rspl_reset_latch.sv ====
`timescale 1ns/1ps
`include "rspl_map.svh"
// How it works
// R1: Self-power sense sampled in config state right after reset release; picks power mode.
// R2: After config the sampled self-power value holds until reset, unless dynamic enabled.
// R3: Controller writes 0x41 to register 0x4134 to enable dynamic switching.
// R4: Switch control register resets to 0xc1, meaning static latching.
// R5: Controller may write the register over the register port.
// R6: With self-power sense in use, fixed-port straps are ignored.
// R7: Controller then sets fixed-port state in internal registers.
// R8: All straps captured at power-on reset and every chip reset rising edge.
// R9: 3.3V regulator enable follows chip reset: on when high, off when low.
// R10: While chip reset is low no configuration is kept.
// R11: Chip reset release synchronised so all straps latch in one cycle.
module rspl_reset_latch #(
   parameter int STRAP_W = 8,
   parameter int PORTS   = 4
)(
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic               ce,
   input  wire logic               chip_reset_n,
   input  wire logic [STRAP_W-1:0] strap_in,
   input  wire logic [1:0]         fixed_port_straps,
   input  wire logic               self_power_sense,
   input  wire logic               sense_in_use,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire logic [15:0]        reg_addr,
   input  wire rspl_pkg::rspl_byte_t reg_wdata,
   output rspl_pkg::rspl_byte_t    reg_rdata,
   output logic                    reg_ack,
   output logic [STRAP_W-1:0]      strap_latched,
   output logic [PORTS-1:0]        fixed_ports,
   output logic                    self_powered,
   output logic                    config_done,
   output logic                    reg33_en
);
   import rspl_pkg::*;
   rspl_state_t      state;
   logic             sync1, sync2, sync3;
   logic [3:0]       cfg_cnt;
   rspl_byte_t       local_supply_switch_cfg;
   logic [PORTS-1:0] fixed_port_reg;
   logic             dynamic_on;
   logic             latch_pulse;
   logic [1:0]       fixed_latched;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      return a == b;
   endfunction

   // ***************************************************************
   // Reset release synchroniser
   // ***************************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end
      else if (ce)
      begin
         sync1 <= chip_reset_n; // R11
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign latch_pulse = sync2 & ~sync3; // R11
   // The regulator follows the pin directly so it can power up the core itself.
   assign reg33_en    = chip_reset_n; // R9

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state   <= RSPL_LATCH; // R8
         cfg_cnt <= 4'h0;
      end
      else if (ce)
      begin
         case (state)
            RSPL_STANDBY:
               if (latch_pulse)
                  state <= RSPL_LATCH; // R8
            RSPL_LATCH:
            begin
               state   <= RSPL_CONFIG;
               cfg_cnt <= 4'h0;
            end
            RSPL_CONFIG:
               if (cfg_cnt == `RSPL_CFG_CYCLES - 4'h1)
                  state <= RSPL_RUN;
               else
                  cfg_cnt <= cfg_cnt + 4'h1;
            RSPL_RUN:
               ;
            default:
               state <= RSPL_STANDBY;
         endcase
         if (!sync2)
            state <= RSPL_STANDBY; // R10
      end
   end

   assign config_done = (state == RSPL_RUN);

   rspl_strap_hold #(.W(STRAP_W)) u_hold (
      .mclk  (mclk),
      .rst   (rst),
      .ce    (ce),
      .clear (!sync2),
      .load  (state == RSPL_LATCH), // R8
      .din   (strap_in),
      .dout  (strap_latched)
   );

   // ***************************************************************
   // Power source and fixed ports
   // ***************************************************************
   assign dynamic_on = (local_supply_switch_cfg == `RSPL_SUPPLY_CFG_DYNAMIC); // R3

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         self_powered <= 1'b0;
      else if (ce)
      begin
         if (!sync2)
            self_powered <= 1'b0; // R10
         else if (state == RSPL_CONFIG && cfg_cnt == 4'h0)
            self_powered <= self_power_sense; // R1
         else if (state == RSPL_RUN && dynamic_on)
            self_powered <= self_power_sense; // R2
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         fixed_ports <= '0;
      else if (ce)
      begin
         if (sense_in_use)
            fixed_ports <= fixed_port_reg; // R6
         else
            fixed_ports <= {{(PORTS-2){1'b0}}, fixed_latched};
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         fixed_latched <= 2'b00;
      else if (ce)
      begin
         if (!sync2)
            fixed_latched <= 2'b00;
         else if (state == RSPL_LATCH)
            fixed_latched <= fixed_port_straps; // R8
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         local_supply_switch_cfg <= `RSPL_SUPPLY_CFG_RESET; // R4
         fixed_port_reg          <= PORTS'(`RSPL_FIXED_RESET);
      end
      else if (ce)
      begin
         if (!sync2)
         begin
            local_supply_switch_cfg <= `RSPL_SUPPLY_CFG_RESET; // R10
            fixed_port_reg          <= PORTS'(`RSPL_FIXED_RESET);
         end
         else if (reg_wr && config_done)
         begin
            if (hit(reg_addr, `RSPL_SUPPLY_CFG_ADDR))
               local_supply_switch_cfg <= reg_wdata; // R5
            if (hit(reg_addr, `RSPL_FIXED_ADDR))
               fixed_port_reg <= reg_wdata[PORTS-1:0]; // R7
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
         reg_ack   <= 1'b0;
      end
      else if (ce)
      begin
         // Writes before configuration ends are dropped, as the core is not stable yet.
         reg_ack <= (reg_wr | reg_rd) & config_done;
         if (reg_rd && hit(reg_addr, `RSPL_SUPPLY_CFG_ADDR))
            reg_rdata <= local_supply_switch_cfg;
         else if (reg_rd && hit(reg_addr, `RSPL_FIXED_ADDR))
            reg_rdata <= {{(8-PORTS){1'b0}}, fixed_port_reg};
         else if (reg_rd && hit(reg_addr, `RSPL_STATUS_ADDR))
            reg_rdata <= {5'h00, config_done, dynamic_on, self_powered};
         else if (reg_rd)
            reg_rdata <= 8'h00;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   sample_after_release_a: assert property (@(posedge mclk) disable iff (rst) // R1
      (ce && state == RSPL_CONFIG && cfg_cnt == 4'h0 && sync2) |=> self_powered == $past(self_power_sense))
      else $error("Self-power sense not sampled in config.");
   static_hold_a: assert property (@(posedge mclk) disable iff (rst) // R2
      (state == RSPL_RUN && !dynamic_on && !$past(dynamic_on) && sync2 && $past(state == RSPL_RUN))
      |-> $stable(self_powered))
      else $error("Self-power value changed while static.");
   cfg_default_a: assert property (@(posedge mclk) disable iff (rst) // R4
      (!$past(sync2) && $past(ce)) |-> local_supply_switch_cfg == 8'hc1)
      else $error("Switch register not at default.");
   fixed_ignore_a: assert property (@(posedge mclk) disable iff (rst) // R6
      (ce && sense_in_use) |=> fixed_ports == $past(fixed_port_reg))
      else $error("Fixed-port straps used with sense active.");
   strap_capture_a: assert property (@(posedge mclk) disable iff (rst) // R8
      (ce && state == RSPL_LATCH && sync2) |=> strap_latched == $past(strap_in))
      else $error("Straps not captured.");
   regulator_pin_a: assert property (@(posedge mclk) disable iff (rst) // R9
      reg33_en == chip_reset_n)
      else $error("Regulator enable not following reset pin.");
   standby_clear_a: assert property (@(posedge mclk) disable iff (rst) // R10
      (ce && !sync2) |=> (state == RSPL_STANDBY && !self_powered && strap_latched == '0))
      else $error("Configuration kept in standby.");
   sync_latch_a: assert property (@(posedge mclk) disable iff (rst) // R11
      (ce && latch_pulse && state == RSPL_STANDBY) |=> state == RSPL_LATCH)
      else $error("Latch not following synchronised release.");
endmodule

// ==== tb/rspl_ctrl_model.sv ====
`timescale 1ns/1ps
// ***************************************************************
// System controller on the register port
// ***************************************************************
module rspl_ctrl_model (
   input  wire logic             mclk,
   output logic                  reg_wr,
   output logic                  reg_rd,
   output logic [15:0]           reg_addr,
   output rspl_pkg::rspl_byte_t  reg_wdata
);
   initial
   begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 16'h0000;
      reg_wdata = 8'h00;
   end

   // One strobe per access; once released, address and data are inverted so stale values never pass.
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr    = wr;
      reg_rd    = ~wr;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "rspl_map.svh"
module testbench;
   import rspl_pkg::*;
   logic        mclk, rst, ce, chip_reset_n, self_power_sense, sense_in_use;
   logic        reg_wr, reg_rd, reg_ack, self_powered, config_done, reg33_en;
   logic [1:0]  fixed_port_straps;
   logic [3:0]  fixed_ports;
   logic [7:0]  strap_in, strap_latched;
   logic [15:0] reg_addr;
   rspl_byte_t  reg_wdata, reg_rdata;
   int          error_cnt, num_checks;
   integer      seed;

   rspl_reset_latch rspl_reset_latch_inst (.mclk(mclk), .rst(rst), .ce(ce), .chip_reset_n(chip_reset_n),
      .strap_in(strap_in), .fixed_port_straps(fixed_port_straps), .self_power_sense(self_power_sense),
      .sense_in_use(sense_in_use), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .strap_latched(strap_latched),
      .fixed_ports(fixed_ports), .self_powered(self_powered), .config_done(config_done), .reg33_en(reg33_en));
   rspl_ctrl_model rspl_ctrl_model_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   always #12.5 mclk = ~mclk;

   // ***************************************************************
   // Checking and closing
   // ***************************************************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test;
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   function automatic logic [7:0] exp_status(input logic dyn, input logic sp);
      return {5'h00, 1'b1, dyn, sp};
   endfunction

   // ***************************************************************
   // Register and reset helpers
   // ***************************************************************
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      rspl_ctrl_model_inst.access(1'b1, a, d);
      check("wr_ack", reg_ack, 8'h01);
   endtask

   task automatic rd(input string n, input logic [15:0] a, input logic [7:0] exp);
      rspl_ctrl_model_inst.access(1'b0, a, 8'h00);
      check("rd_ack", reg_ack, 8'h01);
      check(n, reg_rdata, exp);
   endtask

   task automatic wait_cfg;
      for (int i = 0; i < 40 && config_done !== 1'b1; i++)
         @(negedge mclk);
      check("config_done", config_done, 8'h01);
   endtask

   // A refused write in reset must leave the register at its default afterwards.
   task automatic chip_cycle(input logic [7:0] s, input logic p);
      @(negedge mclk);
      chip_reset_n     = 1'b0;
      strap_in         = s;
      self_power_sense = p;
      repeat (3) @(negedge mclk);
      check("reg33_off", reg33_en, 8'h00);
      check("cfg_low", config_done, 8'h00);
      rspl_ctrl_model_inst.access(1'b1, `RSPL_SUPPLY_CFG_ADDR, `RSPL_SUPPLY_CFG_DYNAMIC);
      check("no_ack", reg_ack, 8'h00);
      chip_reset_n = 1'b1;
      wait_cfg;
      check("reg33_on", reg33_en, 8'h01);
      check("straps", strap_latched, s);
      check("self_pwr", self_powered, p);
      rd("cfg_dflt", `RSPL_SUPPLY_CFG_ADDR, `RSPL_SUPPLY_CFG_RESET);
      rd("status", `RSPL_STATUS_ADDR, exp_status(1'b0, p));
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      mclk              = 1'b0;
      rst               = 1'b1;
      ce                = 1'b1;
      chip_reset_n      = 1'b1;
      seed              = 32'h2f39e0a6;
      strap_in          = 8'($random(seed));
      fixed_port_straps = 2'b11;
      self_power_sense  = 1'b1;
      sense_in_use      = 1'b0;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      wait_cfg;
      check("por_straps", strap_latched, strap_in);
      check("fixed_strap", fixed_ports, 8'h03);
      chip_cycle(8'hff, 1'b1);
      chip_cycle(8'h00, 1'b0);
      for (int k = 0; k < 4; k++)
         chip_cycle(8'($random(seed)), k[0]);
      strap_in         = ~strap_in;
      self_power_sense = 1'b0;
      repeat (6) @(negedge mclk);
      check("strap_hold", strap_latched, ~strap_in);
      check("sp_hold", self_powered, 8'h01);
      wr(`RSPL_SUPPLY_CFG_ADDR, `RSPL_SUPPLY_CFG_DYNAMIC);
      rd("cfg_dyn", `RSPL_SUPPLY_CFG_ADDR, 8'h41);
      repeat (3) @(negedge mclk);
      check("sp_dyn", self_powered, 8'h00);
      rd("status_dyn", `RSPL_STATUS_ADDR, exp_status(1'b1, 1'b0));
      // With the clock enable low the tracked value must not follow the sense input.
      ce               = 1'b0;
      self_power_sense = 1'b1;
      repeat (3) @(negedge mclk);
      check("ce_freeze", self_powered, 8'h00);
      ce = 1'b1;
      repeat (2) @(negedge mclk);
      check("sp_dyn_back", self_powered, 8'h01);
      sense_in_use      = 1'b1;
      fixed_port_straps = 2'($random(seed));
      wr(`RSPL_FIXED_ADDR, 8'h0a);
      repeat (2) @(negedge mclk);
      check("fixed_ports", fixed_ports, 8'h0a);
      rd("unmapped", 16'h4137, 8'h00);
      finish_test;
   end

   initial
   begin
      #(25 * 5000);
      error_cnt++;
      finish_test;
   end
endmodule
